/* logic/selfid_mask_map.svh */
// Summary of operation
// RQ1 - Error bit 31 flags bad self-ID reception
// RQ2 - Error set means buffer contents undefined
// RQ3 - Clean reception completion clears error flag
// RQ4 - Reception or host write errors set flag
// RQ5 - Reserved bits 30-24, 15-11, 1-0 read zero
// RQ6 - Generation field increments on bus reset
// RQ7 - Generation wraps 255 to zero
// RQ8 - Size field counts stored quadlets
// RQ9 - Count includes header and data quadlets
// RQ10 - Count clears when reception starts
// RQ11 - Upper mask gates channels 32 to 63
// RQ12 - Mask bit 31 enables channel 63
// RQ13 - Mask bit n enables channel n+32
// RQ14 - Set or clear address reads mask
// RQ15 - Ones set or clear mask bits
// RQ16 - Zero bits leave mask bits unchanged
// RQ17 - Status word ignores software writes
`ifndef SELFID_MASK_MAP_SVH
`define SELFID_MASK_MAP_SVH
`define SELF_ID_STATUS_OFS 8'h68
`define ISO_RX_UPPER_MASK_SET_OFS 8'h70
`define ISO_RX_UPPER_MASK_CLEAR_OFS 8'h74
`define ERROR_FLAG_BIT 31
`define GENERATION_LSB 16
`define SIZE_LSB 2
`define MASK_RESET 32'h0000_0000
`define CHANNEL_BASE 6'h20
`endif

/* logic/selfid_mask_pkg.sv */
`default_nettype none
package selfid_mask_pkg;
    // Reception tracking phase
    typedef enum logic {
        RX_IDLE,
        RX_BUSY
    } rx_phase_t;
endpackage
`default_nettype wire

/* logic/upper_channel_gate.sv */
`default_nettype none
`include "selfid_mask_map.svh"
// Looks up the enable bit for an upper channel
module upper_channel_gate (
    input wire logic [31:0] mask_in,
    input wire logic [5:0] channel_in,
    output logic enable_out
);
    logic [5:0] idx;
    // Lower channels are not this block's concern
    always_comb
    begin
        idx = channel_in - `CHANNEL_BASE; // RQ13
        enable_out = channel_in[5] & mask_in[idx[4:0]]; // RQ11 RQ12
    end
endmodule
`default_nettype wire

/* logic/selfid_status_iso_rx_mask.sv */
`default_nettype none
`include "selfid_mask_map.svh"
module selfid_status_iso_rx_mask
    import selfid_mask_pkg::*;
#(
    // Field widths; defaults match the status word layout
    parameter int SIZE_W = 9,
    parameter int GEN_W = 8
) (
    // Host register clock and its synchronous reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Register access: one word per cycle, byte address
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // Link-side events, each a one-cycle pulse
    input wire logic bus_reset_in,
    input wire logic selfid_start_in,
    input wire logic quadlet_stored_in,
    input wire logic selfid_done_in,
    input wire logic rx_error_in,
    input wire logic host_write_error_in,
    // Channel filter lookup and mirrors of key state
    input wire logic [5:0] rx_channel_in,
    output logic rx_channel_accept_out,
    output logic [31:0] upper_mask_out,
    output logic self_id_error_flag_out
);
    // Two jobs share this record: self-ID bookkeeping driven by the
    // link side, and the upper receive mask driven by host writes.
    // They touch different fields, so both may update in one cycle.

    // All block state in one record
    typedef struct packed {
        logic [31:0] mask; // Upper channel enables, bit n is channel n+32
        logic [GEN_W-1:0] gen; // Bus reset generation, wraps freely
        logic [SIZE_W-1:0] count; // Quadlets stored since the last reception start
        logic err; // Error flag as software sees it
        logic err_seen; // Fault collected during the running reception
        rx_phase_t phase; // Idle or receiving self-ID packets
        logic [31:0] rdata; // Read data held for the bus
        logic accept; // Registered channel accept decision
    } state_t;

    state_t st_reg; // Present state
    state_t st_next; // Next state, built combinationally
    logic gate_en; // Channel enable lookup
    logic set_hit; // Write strobe at the set alias
    logic rx_fault; // Any error source raised this cycle
    logic start_ok; // Reception start taken while idle
    logic end_ok; // Reception end taken while busy

    // Lookup is combinational; its answer is registered in the record
    upper_channel_gate u_gate (
        .mask_in(st_reg.mask),
        .channel_in(rx_channel_in),
        .enable_out(gate_en)
    );

    // Packs the status word; reserved bits stay zero
    function automatic logic [31:0] status_word(input state_t s);
        logic [31:0] w;
        // Start from zero so every reserved range reads back clear
        w = 32'h0000_0000; // RQ5
        w[`ERROR_FLAG_BIT] = s.err; // RQ1
        w[`GENERATION_LSB +: GEN_W] = s.gen; // RQ6
        w[`SIZE_LSB +: SIZE_W] = s.count; // RQ8
        return w;
    endfunction

    // True at either alias of the upper mask; used for writes and reads
    function automatic logic is_mask_addr(input logic [7:0] a);
        logic hit;
        hit = (a == `ISO_RX_UPPER_MASK_SET_OFS) || (a == `ISO_RX_UPPER_MASK_CLEAR_OFS);
        return hit;
    endfunction

    // One set or clear step: ones act, zeros leave bits alone
    function automatic logic [31:0] mask_write(input logic [31:0] cur,
        input logic [31:0] data, input logic set);
        logic [31:0] res;
        if (set)
        begin
            // Set alias ORs the ones in
            res = cur | data; // RQ15 RQ16
        end
        else
        begin
            // Clear alias knocks the ones out
            res = cur & ~data; // RQ15 RQ16
        end
        return res;
    endfunction

    // Strobe and event decode, kept apart from the state update
    always_comb
    begin
        // Set and clear cannot collide: they are separate addresses
        set_hit = reg_wr_in && (reg_addr_in == `ISO_RX_UPPER_MASK_SET_OFS);
        // Host write faults count as reception faults
        rx_fault = rx_error_in | host_write_error_in; // RQ4
        // Events outside their phase are ignored, not queued
        start_ok = selfid_start_in && (st_reg.phase == RX_IDLE);
        end_ok = selfid_done_in && (st_reg.phase == RX_BUSY);
    end

    // Next-state logic
    always_comb
    begin
        // Hold everything unless an event below says otherwise
        st_next = st_reg;
        // Bus reset advances the generation, wraps at 255
        if (bus_reset_in)
        begin
            st_next.gen = st_reg.gen + 1'b1; // RQ6 RQ7
        end
        // Error during reception remembered until done
        if (st_reg.phase == RX_BUSY && rx_fault)
        begin
            st_next.err_seen = 1'b1; // RQ4
        end
        case (st_reg.phase)
            RX_IDLE:
            begin
                // A new reception starts from an empty count
                if (start_ok)
                begin
                    st_next.count = '0; // RQ10
                    st_next.err_seen = rx_fault; // RQ4
                    st_next.phase = RX_BUSY;
                end
            end
            RX_BUSY:
            begin
                // Header and data quadlets alike are counted
                if (quadlet_stored_in)
                begin
                    // Wraps past its field width; a real bus never gets there
                    st_next.count = st_reg.count + 1'b1; // RQ8 RQ9
                end
                if (end_ok)
                begin
                    // Flag moves only at the end: one verdict per reception,
                    // buffer treated as undefined while it is set
                    st_next.err = st_next.err_seen; // RQ1 RQ2 RQ3
                    st_next.phase = RX_IDLE;
                end
            end
            default:
            begin
                // Unreachable with two phases; recover to idle
                st_next.phase = RX_IDLE;
            end
        endcase
        // Only the two mask aliases take writes
        if (reg_wr_in && is_mask_addr(reg_addr_in))
        begin
            st_next.mask = mask_write(st_reg.mask, reg_wdata_in, set_hit); // RQ15 RQ16
        end
        // Read mux; status writes never reach the record
        if (reg_addr_in == `SELF_ID_STATUS_OFS)
        begin
            st_next.rdata = status_word(st_reg); // RQ17
        end
        else if (is_mask_addr(reg_addr_in))
        begin
            // Both aliases read back the same mask
            st_next.rdata = st_reg.mask; // RQ14
        end
        else
        begin
            // Unmapped offsets read as zero
            st_next.rdata = 32'h0000_0000;
        end
        // Registered so the accept output comes from a flip-flop,
        // at the cost of one cycle of latency on the filter
        st_next.accept = gate_en; // RQ11
    end

    // State register, synchronous reset
    // Mask resets to a fixed value so the filter starts closed
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            // Whole record to known values in one step
            st_reg <= '{mask: `MASK_RESET, phase: RX_IDLE, default: '0};
        end
        else
        begin
            // Normal operation: take the computed next state
            st_reg <= st_next;
        end
    end

    // Outputs taken straight from the record's flip-flops
    assign reg_rdata_out = st_reg.rdata;
    assign rx_channel_accept_out = st_reg.accept;
    assign upper_mask_out = st_reg.mask;
    assign self_id_error_flag_out = st_reg.err;
endmodule
`default_nettype wire

/* tb/selfid_chk.sv */
`default_nettype none
// Port-level checker, one clock domain
module selfid_chk (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic reg_wr_in,
    input wire logic selfid_done_in,
    input wire logic rx_channel_accept_out,
    input wire logic self_id_error_flag_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic [5:0] rx_channel_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [31:0] upper_mask_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic s, k;
    logic [31:0] mo;
    // Set and clear strobes
    assign s = reg_wr_in && reg_addr_in == 8'h70;
    assign k = reg_wr_in && reg_addr_in == 8'h74;
    assign mo = upper_mask_out;
    AST_SET: assert property (s |=> mo == $past(mo | reg_wdata_in))
        else $error("mask set wrong");
    AST_CLR: assert property (k |=> mo == $past(mo & ~reg_wdata_in))
        else $error("mask clear wrong");
    AST_HOLD: assert property (!s && !k |=> $stable(mo))
        else $error("mask moved");
    AST_RD: assert property (reg_addr_in inside {8'h70, 8'h74} && !reg_wr_in |=>
        reg_rdata_out == $past(mo)) else $error("mask read wrong");
    AST_RSV: assert property (reg_addr_in == 8'h68 |=> !(reg_rdata_out & 32'h7F00_F803))
        else $error("reserved set");
    AST_ACC: assert property (!reg_wr_in |=>
        rx_channel_accept_out == $past(rx_channel_in[5] & mo[rx_channel_in[4:0]]))
        else $error("gate wrong");
    AST_LOW: assert property (!rx_channel_in[5] |=> !rx_channel_accept_out)
        else $error("low channel taken");
    AST_ERR: assert property (!selfid_done_in |=> $stable(self_id_error_flag_out))
        else $error("flag moved");
    cover property (s ##1 k);
    cover property (selfid_done_in ##1 self_id_error_flag_out);
    cover property (rx_channel_accept_out);
endmodule
bind selfid_status_iso_rx_mask selfid_chk chk(.*);
`default_nettype wire

/* tb/tb_selfid_status_iso_rx_mask.sv */
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("ERROR %0t bad read", $time); end end
module tb_selfid_status_iso_rx_mask;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 0, nrst_in = 0, reg_wr_in = 0, bus_reset_in = 0, selfid_start_in = 0;
    logic quadlet_stored_in = 0, selfid_done_in = 0, rx_error_in = 0, host_write_error_in = 0;
    logic rd = 0, rp = 0, rx_channel_accept_out, self_id_error_flag_out;
    logic [7:0] reg_addr_in = 0;
    logic [5:0] rx_channel_in = 0;
    logic [31:0] reg_wdata_in = 0, reg_rdata_out, upper_mask_out, m = 0, v;
    logic [31:0] q[$];
    int errors = 0, n_checks = 0, cyc = 0;
    selfid_status_iso_rx_mask dut(.*);
    initial forever #4 core_clk_in = ~core_clk_in;
    // Watchdog, random channel, read pipeline
    always @(posedge core_clk_in)
    begin
        cyc++;
        rp <= rd;
        rx_channel_in <= #1 6'($urandom);
        if (cyc > 5000)
        begin
            errors++;
            end_sim;
        end
    end
    // Oldest note against settled read data
    always @(negedge core_clk_in)
        if (rp) `CK(reg_rdata_out, q.pop_front())
    task automatic p(ref logic s, input int n = 1);
        repeat (n)
        begin
            @(posedge core_clk_in) #1 s = 1;
            @(posedge core_clk_in) #1 s = 0;
        end
    endtask
    task w(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in) #1 {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
        @(posedge core_clk_in) #1 reg_wr_in = 0;
    endtask
    task r(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_in) #1 {reg_addr_in, rd} = {a, 1'b1};
        q.push_back(e);
        @(posedge core_clk_in) #1 rd = 0;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        void'($urandom(25935));
        repeat (3) @(posedge core_clk_in);
        #1 nrst_in = 1;
        r(8'h68, 0);
        repeat (4)
        begin
            v = $urandom;
            w(8'h70, v);
            m |= v;
            `CK(upper_mask_out, m)
            r(8'h74, m);
            v = $urandom;
            w(8'h74, v);
            m &= ~v;
            `CK(upper_mask_out, m)
            r(8'h70, m);
        end
        w(8'h68, '1);
        w(8'h40, '1);
        `CK(upper_mask_out, m)
        r(8'h40, 0);
        r(8'h68, 0);
        p(bus_reset_in, 257);
        for (int e = 0; e < 3; e++)
        begin
            p(selfid_start_in);
            p(quadlet_stored_in, e + 1);
            if (e == 0) p(rx_error_in);
            if (e == 1) p(host_write_error_in);
            p(selfid_done_in);
            `CK(self_id_error_flag_out, e < 2)
            r(8'h68, {e < 2, 15'h0001, 5'h00, 9'(e + 1), 2'h0});
        end
        repeat (2) @(posedge core_clk_in);
        end_sim;
    end
endmodule
`default_nettype wire
